/* adcs_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer (
	input  wire logic                         aclk,            // system clock
	input  wire logic                         aresetn,         // sync reset, low
	input  wire logic [adcs_pkg::ADDR_W-1:0]  s_axi_awaddr,    // write address
	input  wire logic                         s_axi_awvalid,   // write address valid
	output logic                              s_axi_awready,   // write address ready
	input  wire logic [adcs_pkg::DATA_W-1:0]  s_axi_wdata,     // write data
	input  wire logic [3:0]                   s_axi_wstrb,     // byte enables
	input  wire logic                         s_axi_wvalid,    // write data valid
	output logic                              s_axi_wready,    // write data ready
	output logic [1:0]                        s_axi_bresp,     // write response
	output logic                              s_axi_bvalid,    // write response valid
	input  wire logic                         s_axi_bready,    // write response ready
	input  wire logic [adcs_pkg::ADDR_W-1:0]  s_axi_araddr,    // read address
	input  wire logic                         s_axi_arvalid,   // read address valid
	output logic                              s_axi_arready,   // read address ready
	output logic [adcs_pkg::DATA_W-1:0]       s_axi_rdata,     // read data
	output logic [1:0]                        s_axi_rresp,     // read response
	output logic                              s_axi_rvalid,    // read data valid
	input  wire logic                         s_axi_rready,    // read data ready
	input  wire logic                         comparator_high, // analog: input at or above trial
	input  wire logic [adcs_pkg::N_PINS-1:0]  port_pullup_req, // software pull-up per pin
	input  wire logic [adcs_pkg::N_PINS-1:0]  port_output_req, // port direction, 1 = output
	input  wire logic [adcs_pkg::N_PINS-1:0]  port_digital_req,// other pin function wanted
	output logic [adcs_pkg::N_PINS-1:0]       pin_pullup_en,   // pull-up actually on
	output logic [adcs_pkg::N_PINS-1:0]       pin_output_en,   // digital driver on
	output logic [adcs_pkg::N_PINS-1:0]       pin_digital_en,  // digital function on
	output logic [adcs_pkg::N_PINS-1:0]       analog_pin_0_to_5, // pin switched to converter
	output logic [adcs_pkg::N_INT-1:0]        internal_src_en, // amp1 out 0..2, dac, amp2
	output logic [2:0]                        reference_en,    // supply, dac ref, ext pin
	output logic                              converter_power, // analog power on
	output logic                              sample_hold,     // sampling phase active
	output logic [adcs_pkg::RES_W-1:0]        sar_trial,       // trial code to the dac
	output logic                              conv_busy_flag,  // conversion running
	output logic                              conv_irq_req     // interrupt to the cpu
);
	typedef struct packed {
		logic                        aw_full;
		logic [adcs_pkg::ADDR_W-1:0] aw_addr;
		logic                        w_full;
		logic [adcs_pkg::DATA_W-1:0] w_data;
		logic [3:0]                  w_strb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [adcs_pkg::DATA_W-1:0] rdata;
		logic [1:0]                  rresp;
		logic                        start;
		logic                        start_d;
		logic                        pwr;
		logic                        fmt;
		logic [3:0]                  chan;
		logic [2:0]                  div;
		logic [2:0]                  ins;
		logic [1:0]                  refsel;
		logic [adcs_pkg::N_PINS-1:0] pinsel;
		logic                        irq_flag;
		logic                        irq_en;
		logic                        glb_en;
		logic                        busy;
		adcs_pkg::adcs_state_t       state;
		logic [3:0]                  phase;
		logic [adcs_pkg::RES_W-1:0]  sar;
		logic [adcs_pkg::RES_W-1:0]  result;
		logic                        cmp1;
		logic                        cmp2;
		logic                        cmp3;
		logic                        cmp;
	} adcs_regs_t;

	adcs_regs_t s_reg;
	adcs_regs_t s_next;
	logic       tick;
	logic       start_rise;
	logic       start_fall;
	logic       done;
	logic       ext_mode;
	logic       wr_go;
	logic       rd_go;
	logic [3:0] bit_idx;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic [adcs_pkg::DATA_W-1:0] wmask;
	logic [adcs_pkg::DATA_W-1:0] wval;
	logic [adcs_pkg::DATA_W-1:0] ctrl0;
	logic [adcs_pkg::DATA_W-1:0] ctrl1;
	logic [adcs_pkg::DATA_W-1:0] irqr;

	// divider restarts at every launch, the cpu keeps running meanwhile
	adcs_clk_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (s_reg.busy),
		.div_sel (s_reg.div),
		.tick    (tick)
	);

	assign s_axi_awready = !s_reg.aw_full && !s_reg.bvalid;
	assign s_axi_wready  = !s_reg.w_full && !s_reg.bvalid;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;

	assign start_rise = s_reg.start && !s_reg.start_d;
	assign start_fall = !s_reg.start && s_reg.start_d;
	assign done = s_reg.pwr && !start_rise && !start_fall && tick && s_reg.busy
		&& s_reg.phase == adcs_pkg::PHASE_LAST;
	assign bit_idx = adcs_pkg::PHASE_LAST - s_reg.phase;
	assign ext_mode = s_reg.ins == adcs_pkg::INS_EXT || s_reg.ins == adcs_pkg::INS_EXT_ALT0
		|| s_reg.ins == adcs_pkg::INS_EXT_ALT1;

	// pins handed to the converter lose every digital role
	assign pin_pullup_en  = port_pullup_req & ~s_reg.pinsel;
	assign pin_output_en  = port_output_req & ~s_reg.pinsel;
	assign pin_digital_en = port_digital_req & ~s_reg.pinsel;

	// channel codes above the last pin match no index and float the input
	genvar gi;
	generate
		for (gi = 0; gi < adcs_pkg::N_PINS; gi++) begin : g_ext
			assign analog_pin_0_to_5[gi] = s_reg.pwr && ext_mode
				&& s_reg.chan == 4'(gi);
		end
		for (gi = 0; gi < adcs_pkg::N_INT; gi++) begin : g_int
			assign internal_src_en[gi] = s_reg.pwr && s_reg.ins == 3'(gi + 1);
		end
	endgenerate

	assign reference_en[0] = s_reg.refsel == adcs_pkg::REF_SUPPLY;
	assign reference_en[1] = s_reg.refsel == adcs_pkg::REF_DAC;
	assign reference_en[2] = !reference_en[0] && !reference_en[1];
	assign converter_power = s_reg.pwr;
	assign sample_hold     = s_reg.state == adcs_pkg::ADCS_SAMPLE;
	assign sar_trial       = s_reg.sar;
	assign conv_busy_flag  = s_reg.busy;
	assign conv_irq_req    = s_reg.irq_flag && s_reg.irq_en && s_reg.glb_en;

	// result alignment as seen by the two byte registers
	always_comb begin
		if (s_reg.fmt) begin
			res_hi = {4'h0, s_reg.result[11:8]};
			res_lo = s_reg.result[7:0];
		end else begin
			res_hi = s_reg.result[11:4];
			res_lo = {s_reg.result[3:0], 4'h0};
		end
	end

	always_comb begin
		ctrl0 = '0;
		ctrl0[adcs_pkg::C0_START] = s_reg.start;
		ctrl0[adcs_pkg::C0_PWR] = s_reg.pwr;
		ctrl0[adcs_pkg::C0_FMT] = s_reg.fmt;
		ctrl0[adcs_pkg::C0_BUSY] = s_reg.busy;
		ctrl0[adcs_pkg::C0_CHAN +: 4] = s_reg.chan;
		ctrl1 = '0;
		ctrl1[adcs_pkg::C1_DIV +: 3] = s_reg.div;
		ctrl1[adcs_pkg::C1_INS +: 3] = s_reg.ins;
		ctrl1[adcs_pkg::C1_REF +: 2] = s_reg.refsel;
		irqr = '0;
		irqr[adcs_pkg::IRQ_FLAG] = s_reg.irq_flag;
		irqr[adcs_pkg::IRQ_EN] = s_reg.irq_en;
		irqr[adcs_pkg::IRQ_GLB] = s_reg.glb_en;
	end

	always_comb begin
		s_next = s_reg;
		wr_go = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
		rd_go = s_axi_arvalid && !s_reg.rvalid;
		wmask = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
			{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
		wval = '0;

		// write channel: address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_full = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// converter sequence
		s_next.start_d = s_reg.start;
		s_next.cmp1 = comparator_high;
		s_next.cmp2 = s_reg.cmp1;
		s_next.cmp3 = s_reg.cmp2;
		if (s_reg.cmp2 == s_reg.cmp3) begin
			s_next.cmp = s_reg.cmp3;
		end
		if (!s_reg.pwr || start_rise) begin
			s_next.busy = 1'b0;
			s_next.state = adcs_pkg::ADCS_IDLE;
		end else if (start_fall) begin
			s_next.busy = 1'b1;
			s_next.state = adcs_pkg::ADCS_SAMPLE;
			s_next.phase = '0;
			s_next.sar = '0;
		end else if (tick && s_reg.busy) begin
			s_next.phase = s_reg.phase + 4'h1;
			if (s_reg.state == adcs_pkg::ADCS_SAMPLE) begin
				if (s_reg.phase == adcs_pkg::SAMPLE_LAST) begin
					s_next.state = adcs_pkg::ADCS_CONVERT;
					s_next.sar = adcs_pkg::SAR_MSB;
				end
			end else begin
				// keep the trial bit only if the input reached it
				s_next.sar[bit_idx] = s_reg.cmp;
				if (s_reg.phase != adcs_pkg::PHASE_LAST) begin
					s_next.sar[bit_idx - 4'h1] = 1'b1;
				end else begin
					s_next.result = s_next.sar;
					s_next.busy = 1'b0;
					s_next.state = adcs_pkg::ADCS_IDLE;
				end
			end
		end

		// register writes
		if (wr_go) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = adcs_pkg::RESP_OKAY;
			case (s_reg.aw_addr)
				adcs_pkg::OFS_CTRL0: begin
					wval = (ctrl0 & ~wmask) | (s_reg.w_data & wmask);
					s_next.start = wval[adcs_pkg::C0_START];
					s_next.pwr = wval[adcs_pkg::C0_PWR];
					s_next.fmt = wval[adcs_pkg::C0_FMT];
					s_next.chan = wval[adcs_pkg::C0_CHAN +: 4];
				end
				adcs_pkg::OFS_CTRL1: begin
					wval = (ctrl1 & ~wmask) | (s_reg.w_data & wmask);
					s_next.div = wval[adcs_pkg::C1_DIV +: 3];
					s_next.ins = wval[adcs_pkg::C1_INS +: 3];
					s_next.refsel = wval[adcs_pkg::C1_REF +: 2];
				end
				adcs_pkg::OFS_PINSEL: begin
					if (s_reg.w_strb[0]) begin
						s_next.pinsel = s_reg.w_data[adcs_pkg::N_PINS-1:0];
					end
				end
				adcs_pkg::OFS_IRQ: begin
					if (s_reg.w_strb[0]) begin
						s_next.irq_en = s_reg.w_data[adcs_pkg::IRQ_EN];
						s_next.glb_en = s_reg.w_data[adcs_pkg::IRQ_GLB];
						if (s_reg.w_data[adcs_pkg::IRQ_FLAG]) begin
							s_next.irq_flag = 1'b0;
						end
					end
				end
				adcs_pkg::OFS_RESH, adcs_pkg::OFS_RESL: begin
				end
				default: begin
					s_next.bresp = adcs_pkg::RESP_SLVERR;
				end
			endcase
		end
		// completion beats a same-cycle software clear
		if (done) begin
			s_next.irq_flag = 1'b1;
		end

		// register reads
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = adcs_pkg::RESP_OKAY;
			case (s_axi_araddr)
				adcs_pkg::OFS_CTRL0: s_next.rdata = ctrl0;
				adcs_pkg::OFS_CTRL1: s_next.rdata = ctrl1;
				adcs_pkg::OFS_PINSEL: s_next.rdata = 32'(s_reg.pinsel);
				adcs_pkg::OFS_RESH: s_next.rdata = 32'(res_hi);
				adcs_pkg::OFS_RESL: s_next.rdata = 32'(res_lo);
				adcs_pkg::OFS_IRQ: s_next.rdata = irqr;
				default: begin
					s_next.rdata = '0;
					s_next.rresp = adcs_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence seq_launch;
		start_fall && s_reg.pwr;
	endsequence
	sequence seq_finish;
		done ##1 !s_reg.busy;
	endsequence

	a_launch_busy: assert property (seq_launch |=> s_reg.busy && sample_hold
		&& s_reg.phase == 4'h0)
		else $error("falling start did not launch sampling");
	a_rise_abort: assert property (start_rise |=> !s_reg.busy)
		else $error("rising start did not abort");
	a_power_off: assert property (!s_reg.pwr |=> !s_reg.busy)
		else $error("busy while powered off");
	// upper bits were settled before the last period, only bit 0 is new
	a_finish_flag: assert property (seq_finish |-> s_reg.irq_flag
		&& s_reg.result[adcs_pkg::RES_W-1:1] == $past(s_reg.sar[adcs_pkg::RES_W-1:1]))
		else $error("completion left flag or result wrong");
	a_result_hold: assert property ($changed(s_reg.result) |-> $past(done))
		else $error("result changed without a completion");
	a_sample_len: assert property ($rose(s_reg.state == adcs_pkg::ADCS_CONVERT)
		|-> s_reg.phase == 4'h4 && s_reg.sar == adcs_pkg::SAR_MSB)
		else $error("sampling was not four periods");
	a_ext_route: assert property (|analog_pin_0_to_5 |-> ext_mode
		&& s_reg.chan < 4'(adcs_pkg::N_PINS) && $onehot(analog_pin_0_to_5))
		else $error("external pin routed wrongly");
	a_int_route: assert property ($onehot0(internal_src_en)
		&& (|internal_src_en == (s_reg.pwr && !ext_mode)))
		else $error("internal source routed wrongly");
	a_pin_override: assert property (((pin_pullup_en | pin_output_en | pin_digital_en)
		& s_reg.pinsel) == '0)
		else $error("analog pin kept a digital role");
	a_bresp_hold: assert property (s_reg.bvalid && !s_axi_bready |=> s_reg.bvalid
		&& $stable(s_reg.bresp))
		else $error("write response dropped early");
endmodule : adcs_sequencer
`default_nettype wire

/* adcs_pkg.sv */
package adcs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int RES_W = 12;
	localparam int N_PINS = 6;
	localparam int N_INT = 5;
	localparam int DIV_W = 7;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_PINSEL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_RESH = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_RESL = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ = 5'h14;

	// converter_control_0 fields
	localparam int C0_START = 0;
	localparam int C0_PWR = 1;
	localparam int C0_FMT = 2;
	localparam int C0_BUSY = 3;
	localparam int C0_CHAN = 4;
	// converter_control_1 fields
	localparam int C1_DIV = 0;
	localparam int C1_INS = 4;
	localparam int C1_REF = 8;
	// interrupt control fields
	localparam int IRQ_FLAG = 0;
	localparam int IRQ_EN = 1;
	localparam int IRQ_GLB = 2;

	// sequencing, counted in converter clock periods, then the first trial and full-scale codes
	localparam logic [3:0] SAMPLE_LAST = 4'h3;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	localparam logic [RES_W-1:0] SAR_MSB = 12'h800;
	localparam logic [RES_W-1:0] FULL_SCALE = 12'hFFF;

	localparam logic [2:0] INS_EXT = 3'h0;
	localparam logic [2:0] INS_EXT_ALT0 = 3'h6;
	localparam logic [2:0] INS_EXT_ALT1 = 3'h7;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	localparam logic [1:0] REF_DAC = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ADCS_IDLE    = 2'b00,
		ADCS_SAMPLE  = 2'b01,
		ADCS_CONVERT = 2'b10
	} adcs_state_t;
endpackage : adcs_pkg

/* adcs_clk_div.sv */
`timescale 1ns/1ns
`default_nettype none
module adcs_clk_div (
	input  wire logic       aclk,    // system clock
	input  wire logic       aresetn, // sync reset, low
	input  wire logic       run,     // low holds the divider at phase zero
	input  wire logic [2:0] div_sel, // divide by 2**div_sel
	output logic            tick     // one-cycle converter clock enable
);
	typedef struct packed {
		logic [adcs_pkg::DIV_W-1:0] count;
	} adcs_div_t;

	adcs_div_t s_reg;
	adcs_div_t s_next;
	logic [adcs_pkg::DIV_W-1:0] mask;

	// restarting at launch keeps the first period a full one
	always_comb begin
		mask = adcs_pkg::DIV_W'((8'h01 << div_sel) - 8'h01);
		tick = run && ((s_reg.count & mask) == mask);
		s_next = s_reg;
		if (!run) begin
			s_next.count = '0;
		end else if (tick) begin
			s_next.count = '0;
		end else begin
			s_next.count = s_reg.count + adcs_pkg::DIV_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	a_div_period: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && run && div_sel == 3'h1 && $stable(div_sel) |=> !tick)
		else $error("divide by two ticked twice in a row");
endmodule : adcs_clk_div
`default_nettype wire

/* adcs_analog_model.sv */
`timescale 1ns/1ns
`default_nettype none
module adcs_analog_model (
	input  wire logic                       aclk,            // system clock
	input  wire logic                       converter_power, // analog power on
	input  wire logic [adcs_pkg::RES_W-1:0] sar_trial,       // trial code from the converter
	input  wire logic [adcs_pkg::RES_W-1:0] level,           // input level in codes
	output logic                            comparator_high  // level at or above trial
);
	logic toggle_reg = 1'b0;

	// unpowered comparator gives no stable answer, so never a usable last value
	always_ff @(posedge aclk) begin
		toggle_reg <= !toggle_reg;
	end
	always_comb begin
		comparator_high = converter_power ? (level >= sar_trial) : toggle_reg;
	end
endmodule : adcs_analog_model
`default_nettype wire

/* adcs_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer_tb;
	localparam int LIM = 3000;
	logic                        aclk = 1'b0;
	logic                        aresetn = 1'b0;
	logic [adcs_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [adcs_pkg::DATA_W-1:0] s_axi_wdata = '0;
	logic [adcs_pkg::DATA_W-1:0] s_axi_rdata;
	logic [1:0]                  s_axi_bresp, s_axi_rresp;
	logic [3:0]                  s_axi_wstrb = 4'hF;
	logic                        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                        s_axi_rvalid, comparator_high, converter_power, sample_hold;
	logic                        conv_busy_flag, conv_irq_req;
	logic [adcs_pkg::N_PINS-1:0] port_pullup_req = '0, port_output_req = '0, port_digital_req = '0;
	logic [adcs_pkg::N_PINS-1:0] pin_pullup_en, pin_output_en, pin_digital_en, analog_pin_0_to_5;
	logic [adcs_pkg::N_INT-1:0]  internal_src_en;
	logic [2:0]                  reference_en;
	logic [adcs_pkg::RES_W-1:0]  sar_trial, level = '0, last = '0;
	logic [33:0]                 rq[$];
	logic [1:0]                  bq[$];
	logic [31:0]                 cq[$];
	logic [33:0]                 rexp;
	logic [31:0]                 cexp;
	int                          fails = 0;
	int                          n_tests = 0;
	int                          bc = 0;
	int                          sc = 0;

	adcs_sequencer adcs_sequencer_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .comparator_high, .port_pullup_req, .port_output_req,
		.port_digital_req, .pin_pullup_en, .pin_output_en, .pin_digital_en, .analog_pin_0_to_5,
		.internal_src_en, .reference_en, .converter_power, .sample_hold, .sar_trial,
		.conv_busy_flag, .conv_irq_req
	);
	adcs_analog_model adcs_analog_model_i (
		.aclk, .converter_power, .sar_trial, .level, .comparator_high
	);

	initial begin
		forever #20 aclk = !aclk;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bound(input int n);
		if (n >= LIM) begin
			fails++;
			$display("[FAIL] %0t wait limit reached", $time);
			end_of_test();
		end
	endtask : bound

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		bq.push_back(a > adcs_pkg::OFS_IRQ ? adcs_pkg::RESP_SLVERR : adcs_pkg::RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
		end while (s_axi_bready && n < LIM);
		bound(n);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		n = 0;
		rq.push_back({r, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b0;
		end while (s_axi_rready && n < LIM);
		bound(n);
	endtask : rd

	// results are matched here against the oldest note of the driver
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			chk(32'(s_axi_bresp), 32'(bq.pop_front()));
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rexp = rq.pop_front();
			chk(32'(s_axi_rresp), 32'(rexp[33:32]));
			chk(s_axi_rdata, rexp[31:0]);
		end
		if (conv_busy_flag === 1'b1) begin
			bc++;
			sc += int'(sample_hold === 1'b1);
		end else if (bc != 0) begin
			cexp = cq.pop_front();
			if (cexp != 32'h0) begin
				chk(32'(bc), 32'(cexp[31:16]));
				chk(32'(sc), 32'(cexp[15:0]));
			end
			bc = 0;
			sc = 0;
		end
	end

	task automatic conv(input logic [2:0] dv, input logic [11:0] lv, input logic fmt,
			input logic ie, input logic ab);
		logic [31:0] c0;
		int n;
		c0 = 32'h2 | (32'(fmt) << 2);
		n = 0;
		level <= lv;
		wr(adcs_pkg::OFS_CTRL1, 32'(dv));
		wr(adcs_pkg::OFS_IRQ, 32'h5 | (32'(ie) << 1));
		wr(adcs_pkg::OFS_CTRL0, c0 | 32'h1);
		wr(adcs_pkg::OFS_CTRL0, c0);
		cq.push_back(ab ? 32'h0 : {16'(16 << dv), 16'(4 << dv)});
		rd(adcs_pkg::OFS_CTRL0, c0 | 32'h8, adcs_pkg::RESP_OKAY);
		if (ab) begin
			wr(adcs_pkg::OFS_CTRL0, c0 | 32'h1);
		end
		while (conv_busy_flag !== 1'b0 && n < LIM) begin
			@(posedge aclk);
			n++;
		end
		bound(n);
		chk(32'(conv_irq_req), 32'(ie & !ab));
		rd(adcs_pkg::OFS_IRQ, 32'h4 | (32'(ie) << 1) | 32'(!ab), adcs_pkg::RESP_OKAY);
		// the comparator sync needs four cycles, so periods under eight lose bits;
		// for those only the timing is judged
		if (!ab && dv > 3'h2) begin
			last = lv;
		end
		if (ab || dv > 3'h2) begin
			rd(adcs_pkg::OFS_RESH, fmt ? 32'(last[11:8]) : 32'(last[11:4]),
				adcs_pkg::RESP_OKAY);
			rd(adcs_pkg::OFS_RESL, fmt ? 32'(last[7:0]) : 32'({last[3:0], 4'h0}),
				adcs_pkg::RESP_OKAY);
		end
		wr(adcs_pkg::OFS_IRQ, 32'h5 | (32'(ie) << 1));
		chk(32'(conv_irq_req), 32'h0);
		$display("test conversion div %0d abort %0d done", dv, ab);
	endtask : conv

	initial begin
		int ps;
		bit ext;
		void'($urandom(32'h4496));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(reference_en), 32'h4);
		rd(adcs_pkg::OFS_CTRL0, 32'h0, adcs_pkg::RESP_OKAY);
		rd(5'h18, 32'h0, adcs_pkg::RESP_SLVERR);
		wr(5'h18, 32'hFFFF_FFFF);
		wr(adcs_pkg::OFS_RESH, 32'hFF);
		rd(adcs_pkg::OFS_RESH, 32'h0, adcs_pkg::RESP_OKAY);
		$display("test reset and map done");
		repeat (6) begin
			ps = $urandom;
			port_pullup_req <= 6'($urandom);
			port_output_req <= 6'($urandom);
			port_digital_req <= 6'($urandom);
			wr(adcs_pkg::OFS_PINSEL, 32'(ps[5:0]));
			chk(32'(pin_pullup_en), 32'(port_pullup_req & ~ps[5:0]));
			chk(32'(pin_output_en), 32'(port_output_req & ~ps[5:0]));
			chk(32'(pin_digital_en), 32'(port_digital_req & ~ps[5:0]));
		end
		$display("test pin sharing done");
		wr(adcs_pkg::OFS_CTRL0, 32'h2);
		for (int ins = 0; ins < 8; ins++) begin
			for (int ch = 0; ch < 16; ch++) begin
				ext = (ins == 0 || ins > 5);
				if (ext || ch > 5) begin
					// pins are dropped before an internal source goes on
					if (!ext) wr(adcs_pkg::OFS_CTRL0, 32'(ch * 16 + 2));
					// no reference pin function is driven here, so it stays free
					wr(adcs_pkg::OFS_CTRL1, 32'((ch % 4) * 256 + ins * 16));
					if (ext) wr(adcs_pkg::OFS_CTRL0, 32'(ch * 16 + 2));
					chk(32'(analog_pin_0_to_5), (ext && ch < 6) ? 32'(1 << ch) : 32'h0);
					chk(32'(internal_src_en), ext ? 32'h0 : 32'(1 << (ins - 1)));
					chk(32'(reference_en), ch % 4 == 1 ? 32'h1 : ch % 4 == 2 ? 32'h2 : 32'h4);
				end
			end
		end
		$display("test input select done");
		wr(adcs_pkg::OFS_CTRL0, 32'h0);
		chk(32'(converter_power), 32'h0);
		chk(32'(analog_pin_0_to_5), 32'h0);
		wr(adcs_pkg::OFS_CTRL0, 32'h2);
		chk(32'(converter_power), 32'h1);
		$display("test power done");
		for (int d = 0; d < 8; d++) begin
			conv(3'(d), 12'($urandom), d[0], d[1], 1'b0);
		end
		conv(3'h3, 12'h000, 1'b1, 1'b1, 1'b0);
		conv(3'h3, 12'hFFF, 1'b0, 1'b1, 1'b0);
		conv(3'h3, 12'($urandom), 1'b0, 1'b1, 1'b1);
		end_of_test();
	end
endmodule : adcs_sequencer_tb
`default_nettype wire
